// *** logic/sss_defs.svh ***
// Purpose: Offsets, field positions and reset values of the signal switch
// Assumes: Included by bare name wherever the numbers are needed
// Notes:   Definitions only
`ifndef SSS_DEFS_SVH
`define SSS_DEFS_SVH

// =====================================================================
// Register byte offsets
`define SSS_ADDR_W        8
`define SSS_OFF_RX_CTRL   8'h00
`define SSS_OFF_TX_CTRL   8'h04
`define SSS_OFF_OUT_SEL   8'h08
`define SSS_OFF_TEST_SEL  8'h0C
`define SSS_OFF_STATUS    8'h10

// =====================================================================
// Field positions
`define SSS_DEC_LSB       0
`define SSS_DEC_MSB       1
`define SSS_MOD_LSB       0
`define SSS_MOD_MSB       1
`define SSS_OUT_LSB       0
`define SSS_OUT_MSB       2
`define SSS_TEST_BIT      0
`define SSS_STAT_RATE_BIT 0
`define SSS_STAT_IN_BIT   1
`define SSS_STAT_OUT_BIT  2

// =====================================================================
// Reset values
`define SSS_DEC_RST       2'h1
`define SSS_MOD_RST       2'h2
`define SSS_OUT_RST       3'h0
`define SSS_TEST_RST      1'h0

// =====================================================================
// Bus encodings
`define SSS_HTRANS_NONSEQ 2'h2
`define SSS_HRESP_OKAY    1'h0
`define SSS_WORD_ZERO     32'h0000_0000

`endif

// *** logic/sss_pkg.sv ***
// Purpose: Types shared by the signal switch modules
// Assumes: Selector codes as seen by software
// Notes:   Numbers live in sss_defs.svh
package sss_pkg;

   // ==================================================================
   // Selector codes
   typedef enum logic [1:0] {
      SSS_DEC_ZERO      = 2'h0,
      SSS_DEC_ANALOG    = 2'h1,
      SSS_DEC_PIN_SUBC  = 2'h2,
      SSS_DEC_PIN_MANCH = 2'h3
   } sss_dec_src_t;

   typedef enum logic [1:0] {
      SSS_MOD_OFF        = 2'h0,
      SSS_MOD_CW         = 2'h1,
      SSS_MOD_ENCODER    = 2'h2,
      SSS_MOD_PIN_MILLER = 2'h3
   } sss_mod_src_t;

   typedef enum logic [2:0] {
      SSS_OUT_LOW      = 3'h0,
      SSS_OUT_HIGH     = 3'h1,
      SSS_OUT_ENVELOPE = 3'h2,
      SSS_OUT_TX_BITS  = 3'h3,
      SSS_OUT_RX_REGEN = 3'h4,
      SSS_OUT_SUBC_MAN = 3'h5,
      SSS_OUT_RSV6     = 3'h6,
      SSS_OUT_RSV7     = 3'h7
   } sss_out_sel_t;

   // ==================================================================
   // Bundles
   typedef struct packed {
      sss_dec_src_t dec;
      sss_mod_src_t modsrc;
      sss_out_sel_t outsel;
      logic         test_route;
   } sss_sel_t;

   typedef struct packed {
      logic analog_rx;
      logic encoder_env;
      logic tx_bits;
      logic rx_regen;
      logic subc_manch;
      logic test_sig;
   } sss_core_t;

   typedef struct packed {
      logic decoder_in;
      logic modulator;
      logic output_pin;
   } sss_route_t;

endpackage

// *** logic/sss_ahb_slave.sv ***
// Purpose: AHB-Lite address and data phase tracking for the switch
// Assumes: Zero wait states, single word transfers
// Notes:   Write strobe comes in the data phase, read in the address phase
`timescale 1ns/1ns
`include "sss_defs.svh"
module sss_ahb_slave #(
   parameter int ADDR_W = `SSS_ADDR_W
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // Bus address phase
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic              hready,
   // Decoded accesses
   output logic                   wr_en,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic                   rd_en,
   output logic [ADDR_W-1:0]      rd_addr
);
   logic              dp_write_r;
   logic [ADDR_W-1:0] dp_addr_r;
   logic              take_addr;

   generate
      if (ADDR_W < 5) begin : g_bad
         $error("sss_ahb_slave: ADDR_W too small for the map");
      end
   endgenerate

   // Address phase accepted this cycle
   assign take_addr = hsel && hready && (htrans == `SSS_HTRANS_NONSEQ);
   assign rd_en     = take_addr && !hwrite;
   assign rd_addr   = haddr;
   assign wr_en     = dp_write_r;
   assign wr_addr   = dp_addr_r;

   // Remember a pending write for its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write_r <= 1'b0;
         dp_addr_r  <= '0;
      end else if (hready) begin
         dp_write_r <= take_addr && hwrite;
         dp_addr_r  <= haddr;
      end
   end
endmodule // sss_ahb_slave

// *** logic/sss_route_mux.sv ***
// Purpose: Combinational selectors of the serial signal switch
// Assumes: All inputs synchronous to hclk
// Notes:   Result is registered by the top, so no glitch leaves the block
`timescale 1ns/1ns
module sss_route_mux #(
   parameter int N_DRIVE = 2
) (
   // Settings
   input  sss_pkg::sss_sel_t    sel,
   input  wire logic            rate_106a,
   // Sources
   input  sss_pkg::sss_core_t   core,
   input  wire logic            in_pin,
   // Results
   output sss_pkg::sss_route_t  route,
   output logic [N_DRIVE-1:0]   drive
);
   import sss_pkg::*;

   logic pin_ok;

   // Input pin honoured only at the base rate
   assign pin_ok = in_pin && rate_106a;

   // Decoder, modulator and output pin selection
   always_comb begin
      route = '0;
      case (sel.dec)
         SSS_DEC_ZERO:      route.decoder_in = 1'b0;
         SSS_DEC_ANALOG:    route.decoder_in = core.analog_rx;
         SSS_DEC_PIN_SUBC:  route.decoder_in = pin_ok;
         SSS_DEC_PIN_MANCH: route.decoder_in = pin_ok;
         default:           route.decoder_in = 1'b0;
      endcase
      case (sel.modsrc)
         SSS_MOD_OFF:        route.modulator = 1'b0;
         SSS_MOD_CW:         route.modulator = 1'b1;
         SSS_MOD_ENCODER:    route.modulator = core.encoder_env;
         SSS_MOD_PIN_MILLER: route.modulator = pin_ok;
         default:            route.modulator = 1'b0;
      endcase
      if (sel.test_route) begin
         route.output_pin = core.test_sig;
      end else begin
         case (sel.outsel)
            SSS_OUT_LOW:      route.output_pin = 1'b0;
            SSS_OUT_HIGH:     route.output_pin = 1'b1;
            SSS_OUT_ENVELOPE: route.output_pin = core.encoder_env;
            SSS_OUT_TX_BITS:  route.output_pin = core.tx_bits;
            SSS_OUT_RX_REGEN: route.output_pin = core.rx_regen && rate_106a;
            SSS_OUT_SUBC_MAN: route.output_pin = core.subc_manch && rate_106a;
            default:          route.output_pin = 1'b0;
         endcase
      end
   end

   // Same modulation on every antenna drive
   genvar i;
   generate
      for (i = 0; i < N_DRIVE; i++) begin : g_drive
         assign drive[i] = route.modulator;
      end
   endgenerate
endmodule // sss_route_mux

// *** logic/sss_switch.sv ***
// Purpose: Serial signal switch between coding logic and RF front end
// Assumes: AHB-Lite register access, 100 MHz hclk, synchronous inputs
// Notes:   Every output is a flip-flop
//
// What this block does
// - Decoder input chosen from zero, analog, pin
// - Decoder input resets to analog receiver
// - Modulator source: off, carrier, encoder, pin
// - Modulator source resets to internal encoder
// - Output pin chosen by three-bit code
// - Test route bit overrides output selector
// - Input pin used only at base rate
// - Manchester outputs only at base rate
// - Split setup codes selectable for decoder, modulator and output pin
// - Split setup only at base rate
`timescale 1ns/1ns
`include "sss_defs.svh"
module sss_switch #(
   parameter int N_DRIVE = 2
) (
   // Clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic [31:0]                hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Internal coding and analog signals
   input  sss_pkg::sss_core_t         core_in,
   input  wire logic                  rate_106a,
   // Switch pins and routed outputs
   input  wire logic                  serial_switch_input_pin,
   output logic                       serial_switch_output_pin,
   output logic                       decoder_input,
   output logic [N_DRIVE-1:0]         antenna_drive
);
   import sss_pkg::*;

   // ==================================================================
   // Declarations
   localparam int AW = `SSS_ADDR_W;

   sss_sel_t            sel_r;
   sss_sel_t            sel_nxt;
   sss_route_t          route;
   logic [N_DRIVE-1:0]  drive;
   logic                wr_en;
   logic [AW-1:0]       wr_addr;
   logic                rd_en;
   logic [AW-1:0]       rd_addr;
   logic [31:0]         rd_val;
   logic [31:0]         hrdata_r;
   logic                hreadyout_r;
   logic                hresp_r;
   logic                out_pin_r;
   logic                dec_in_r;
   logic [N_DRIVE-1:0]  drive_r;

   generate
      if (N_DRIVE < 1) begin : g_bad
         $error("sss_switch: N_DRIVE must be at least one");
      end
   endgenerate

   // ==================================================================
   // Bus slave
   sss_ahb_slave #(
      .ADDR_W (AW)
   ) u_bus (
      .hclk    (hclk),
      .hresetn (hresetn),
      .hsel    (hsel),
      .haddr   (haddr[AW-1:0]),
      .htrans  (htrans),
      .hwrite  (hwrite),
      .hready  (hready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .rd_en   (rd_en),
      .rd_addr (rd_addr)
   );

   // ==================================================================
   // Selector registers
   // Next selection from a data-phase write
   always_comb begin
      sel_nxt = sel_r;
      if (wr_en) begin
         case (wr_addr)
            `SSS_OFF_RX_CTRL:
               sel_nxt.dec = sss_dec_src_t'(hwdata[`SSS_DEC_MSB:`SSS_DEC_LSB]);
            `SSS_OFF_TX_CTRL:
               sel_nxt.modsrc =
                  sss_mod_src_t'(hwdata[`SSS_MOD_MSB:`SSS_MOD_LSB]);
            `SSS_OFF_OUT_SEL:
               sel_nxt.outsel =
                  sss_out_sel_t'(hwdata[`SSS_OUT_MSB:`SSS_OUT_LSB]);
            `SSS_OFF_TEST_SEL:
               sel_nxt.test_route = hwdata[`SSS_TEST_BIT];
            default: sel_nxt = sel_r;
         endcase
      end
   end

   // Selector storage with documented defaults
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_r.dec        <= sss_dec_src_t'(`SSS_DEC_RST);
         sel_r.modsrc     <= sss_mod_src_t'(`SSS_MOD_RST);
         sel_r.outsel     <= sss_out_sel_t'(`SSS_OUT_RST);
         sel_r.test_route <= `SSS_TEST_RST;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // ==================================================================
   // Read path
   // Read value uses next selection so a write is seen at once
   always_comb begin
      rd_val = `SSS_WORD_ZERO;
      case (rd_addr)
         `SSS_OFF_RX_CTRL:
            rd_val[`SSS_DEC_MSB:`SSS_DEC_LSB] = sel_nxt.dec;
         `SSS_OFF_TX_CTRL:
            rd_val[`SSS_MOD_MSB:`SSS_MOD_LSB] = sel_nxt.modsrc;
         `SSS_OFF_OUT_SEL:
            rd_val[`SSS_OUT_MSB:`SSS_OUT_LSB] = sel_nxt.outsel;
         `SSS_OFF_TEST_SEL:
            rd_val[`SSS_TEST_BIT] = sel_nxt.test_route;
         `SSS_OFF_STATUS: begin
            rd_val[`SSS_STAT_RATE_BIT] = rate_106a;
            rd_val[`SSS_STAT_IN_BIT]   = serial_switch_input_pin;
            rd_val[`SSS_STAT_OUT_BIT]  = out_pin_r;
         end
         default: rd_val = `SSS_WORD_ZERO;
      endcase
   end

   // Read data captured at address phase, shown in data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= `SSS_WORD_ZERO;
      end else if (rd_en) begin
         hrdata_r <= rd_val;
      end
   end

   // Ready from the first clock after reset, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_r <= 1'b0;
         hresp_r     <= `SSS_HRESP_OKAY;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r     <= `SSS_HRESP_OKAY;
      end
   end

   assign hrdata    = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp     = hresp_r;

   // ==================================================================
   // Routing
   sss_route_mux #(
      .N_DRIVE (N_DRIVE)
   ) u_mux (
      .sel       (sel_r),
      .rate_106a (rate_106a),
      .core      (core_in),
      .in_pin    (serial_switch_input_pin),
      .route     (route),
      .drive     (drive)
   );

   // Routed signals registered so no decode glitch reaches a pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_pin_r <= 1'b0;
         dec_in_r  <= 1'b0;
         drive_r   <= '0;
      end else begin
         out_pin_r <= route.output_pin;
         dec_in_r  <= route.decoder_in;
         drive_r   <= drive;
      end
   end

   assign serial_switch_output_pin = out_pin_r;
   assign decoder_input            = dec_in_r;
   assign antenna_drive            = drive_r;

   // ==================================================================
   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic first_r;

   // Marks the first cycle after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   sequence s_out_write;
      wr_en && (wr_addr == `SSS_OFF_OUT_SEL) && !sel_r.test_route;
   endsequence

   sequence s_out_applied;
      ##1 (sel_r.outsel
           == sss_out_sel_t'($past(hwdata[`SSS_OUT_MSB:`SSS_OUT_LSB])))
      ##1 (sel_r.outsel != SSS_OUT_HIGH
           || serial_switch_output_pin);
   endsequence

   a_dec_zero_src: assert property (
      sel_r.dec == SSS_DEC_ZERO |=> !decoder_input)
      else $error("decoder input not zero for code zero");

   a_dec_analog_path: assert property (
      !first_r && sel_r.dec == SSS_DEC_ANALOG
      |=> decoder_input == $past(core_in.analog_rx))
      else $error("decoder input does not follow analog receiver");

   a_dec_reset_default: assert property (
      first_r |-> sel_r.dec == SSS_DEC_ANALOG)
      else $error("decoder source wrong after reset");

   a_mod_src_off: assert property (
      sel_r.modsrc == SSS_MOD_OFF |=> antenna_drive == '0)
      else $error("carrier not off for modulator code zero");

   a_mod_reset_default: assert property (
      first_r |-> sel_r.modsrc == SSS_MOD_ENCODER)
      else $error("modulator source wrong after reset");

   a_out_tx_bits: assert property (
      !sel_r.test_route && sel_r.outsel == SSS_OUT_TX_BITS
      |=> serial_switch_output_pin == $past(core_in.tx_bits))
      else $error("output pin does not carry transmit bits");

   a_test_override: assert property (
      sel_r.test_route
      |=> serial_switch_output_pin == $past(core_in.test_sig))
      else $error("test route does not override output select");

   a_pin_rate_gate: assert property (
      !rate_106a && sel_r.dec == SSS_DEC_PIN_MANCH |=> !decoder_input)
      else $error("input pin used outside base rate");

   a_manch_rate_gate: assert property (
      !rate_106a && !sel_r.test_route
      && sel_r.outsel == SSS_OUT_SUBC_MAN |=> !serial_switch_output_pin)
      else $error("Manchester output shown outside base rate");

   a_write_applies: assert property (
      s_out_write |-> s_out_applied)
      else $error("output selection not applied one cycle after write");

   a_mod_cw_on: assert property (
      sel_r.modsrc == SSS_MOD_CW |=> antenna_drive == '1)
      else $error("carrier not continuous for modulator code one");

   a_mod_encoder_path: assert property (
      !first_r && sel_r.modsrc == SSS_MOD_ENCODER
      |=> antenna_drive == {N_DRIVE{$past(core_in.encoder_env)}})
      else $error("carrier does not follow encoder envelope");

   a_mod_pin_miller: assert property (
      rate_106a && sel_r.modsrc == SSS_MOD_PIN_MILLER
      |=> antenna_drive == {N_DRIVE{$past(serial_switch_input_pin)}})
      else $error("carrier does not follow input pin in split setup");

   a_dec_pin_path: assert property (
      rate_106a && sel_r.dec == SSS_DEC_PIN_SUBC
      |=> decoder_input == $past(serial_switch_input_pin))
      else $error("decoder input does not follow input pin");

   a_out_const_high: assert property (
      !sel_r.test_route && sel_r.outsel == SSS_OUT_HIGH
      |=> serial_switch_output_pin)
      else $error("output pin not high for code one");

   a_out_reserved: assert property (
      !sel_r.test_route && sel_r.outsel inside {SSS_OUT_RSV6, SSS_OUT_RSV7}
      |=> !serial_switch_output_pin)
      else $error("output pin not low for a reserved code");

endmodule // sss_switch

// *** tb/sss_far_side.sv ***
// Purpose: Far-side model driving the serial switch input pin
// Assumes: Stands for the other reader's section at the base rate
// Notes:   Line has no pull, so it scrambles outside frames
`timescale 1ns/1ns
module sss_far_side (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Frame control
   input  wire logic frame_on,
   input  wire logic rate_106a,
   // Link pins
   input  wire logic peer_pin,
   output logic      pin_out
);
   logic [7:0] pat_r;

   // =================================================================
   // Pattern stream, fed back from the peer's output pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pat_r   <= 8'hB4;
         pin_out <= 1'b0;
      end else if (frame_on && rate_106a) begin
         pat_r   <= {pat_r[6:0], pat_r[7] ^ peer_pin};
         pin_out <= pat_r[7];
      end else begin
         pin_out <= ~pin_out; // Released line shows no stable level
      end
   end
endmodule // sss_far_side

// *** tb/sss_switch_bench.sv ***
// Purpose: Self-checking bench of the serial signal switch
// Assumes: Single AHB-Lite slave, hready tied to hreadyout
// Notes:   A negedge monitor predicts every routed output each cycle
`timescale 1ns/1ns
`include "sss_defs.svh"
module sss_switch_bench;
   import sss_pkg::*;

   localparam int LIMIT = 20000;

   // =================================================================
   // Signals
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   sss_core_t   core_in;
   logic        rate_106a;
   logic        in_pin;
   logic        out_pin;
   logic        dec_in;
   logic [1:0]  ant_drv;
   logic        frame_on;
   logic        mon_on;
   logic [7:0]  s_sel;
   logic [7:0]  p_sel;
   sss_core_t   p_core;
   logic        p_pin;
   logic        p_rate;
   logic [4:0]  e_vec;
   logic [4:0]  g_vec;
   int          mismatches;
   int          n_tests;
   int          cyc;

   // =================================================================
   // Design and far side
   sss_switch #(.N_DRIVE(2)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .core_in(core_in), .rate_106a(rate_106a),
      .serial_switch_input_pin(in_pin),
      .serial_switch_output_pin(out_pin),
      .decoder_input(dec_in), .antenna_drive(ant_drv)
   );
   sss_far_side u_far (
      .hclk(hclk), .hresetn(hresetn), .frame_on(frame_on),
      .rate_106a(rate_106a), .peer_pin(out_pin), .pin_out(in_pin)
   );

   // Clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // Internal sources walk through all 64 combinations
   always @(posedge hclk) core_in <= sss_core_t'(6'(core_in) + 6'h0B);

   // =================================================================
   // Checking
   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Prediction of {decoder, modulator, pin, drive one, drive zero}
   function automatic logic [4:0] exp_route(input logic [7:0] s,
      input sss_core_t c, input logic pn, input logic rt);
      logic d;
      logic m;
      logic o;
      case (s[7:6])
         2'h0:    d = 1'b0;
         2'h1:    d = c.analog_rx;
         default: d = pn & rt;
      endcase
      case (s[5:4])
         2'h0:    m = 1'b0;
         2'h1:    m = 1'b1;
         2'h2:    m = c.encoder_env;
         default: m = pn & rt;
      endcase
      case (s[3:1])
         3'h0:    o = 1'b0;
         3'h1:    o = 1'b1;
         3'h2:    o = c.encoder_env;
         3'h3:    o = c.tx_bits;
         3'h4:    o = c.rx_regen & rt;
         3'h5:    o = c.subc_manch & rt;
         default: o = 1'b0;
      endcase
      if (s[0]) o = c.test_sig;
      return {d, m, o, m, m};
   endfunction

   // Outputs must show last cycle's sources under last cycle's selection
   always @(negedge hclk) begin
      if (mon_on) begin
         e_vec = exp_route(p_sel, p_core, p_pin, p_rate);
         g_vec = {dec_in, ant_drv[0], out_pin, ant_drv};
         chk("route", 32'(e_vec), 32'(g_vec));
      end
      p_sel  = s_sel;
      p_core = core_in;
      p_pin  = in_pin;
      p_rate = rate_106a;
   end

   // =================================================================
   // Bus and helpers
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      chk("hresp", 32'h0000_0000, 32'(hresp));
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      case (a)
         `SSS_OFF_RX_CTRL:  s_sel[7:6] = d[1:0];
         `SSS_OFF_TX_CTRL:  s_sel[5:4] = d[1:0];
         `SSS_OFF_OUT_SEL:  s_sel[3:1] = d[2:0];
         `SSS_OFF_TEST_SEL: s_sel[0] = d[0];
         default: ;
      endcase
   endtask

   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] ex);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(nm, ex, q);
   endtask

   task automatic do_reset();
      mon_on  <= 1'b0;
      s_sel   = 8'h60;
      hresetn <= 1'b0;
      idle(2);
      hresetn <= 1'b1;
      idle(3);
      mon_on  <= 1'b1;
   endtask

   // Every code at both rates, stray upper bits written, read right after
   task automatic sweep(input logic [7:0] a, input int n);
      for (int r = 0; r < 2; r++) begin
         rate_106a <= r[0];
         for (int i = 0; i < n; i++) begin
            wr(a, 32'hFFFF_FFF8 | 32'(i));
            rd("field readback", a, 32'(i));
            idle(6);
         end
      end
   endtask

   // =================================================================
   // Scenarios
   task automatic t_reset_values();
      logic [31:0] q;
      rd("decoder select", `SSS_OFF_RX_CTRL, 32'h0000_0001);
      rd("modulator select", `SSS_OFF_TX_CTRL, 32'h0000_0002);
      rd("output select", `SSS_OFF_OUT_SEL, 32'h0000_0000);
      rd("test route", `SSS_OFF_TEST_SEL, 32'h0000_0000);
      wr(8'h14, 32'hFFFF_FFFF);
      rd("unmapped", 8'h14, 32'h0000_0000);
      idle(6);
      wr(`SSS_OFF_RX_CTRL, 32'h0000_0003);
      wr(`SSS_OFF_TX_CTRL, 32'h0000_0000);
      idle(4);
      do_reset();
      rd("dec after reset", `SSS_OFF_RX_CTRL, 32'h0000_0001);
      rd("mod after reset", `SSS_OFF_TX_CTRL, 32'h0000_0002);
      // Status: rate high, output pin low; input pin level masked
      bus(1'b0, `SSS_OFF_STATUS, 32'h0000_0000, q);
      chk("status", 32'h0000_0001, q & 32'hFFFF_FFFD);
      idle(4);
   endtask

   task automatic t_decoder_codes();
      frame_on <= 1'b1;
      sweep(`SSS_OFF_RX_CTRL, 4);
   endtask

   task automatic t_modulator_codes();
      sweep(`SSS_OFF_TX_CTRL, 4);
   endtask

   task automatic t_output_codes();
      sweep(`SSS_OFF_OUT_SEL, 8);
   endtask

   task automatic t_test_route();
      wr(`SSS_OFF_OUT_SEL, 32'h0000_0001);
      wr(`SSS_OFF_TEST_SEL, 32'h0000_0001);
      idle(8);
      rd("test route", `SSS_OFF_TEST_SEL, 32'h0000_0001);
      wr(`SSS_OFF_TEST_SEL, 32'h0000_0000);
      idle(4);
   endtask

   task automatic t_split();
      rate_106a <= 1'b1;
      frame_on  <= 1'b1;
      wr(`SSS_OFF_TX_CTRL, 32'h0000_0003);
      wr(`SSS_OFF_OUT_SEL, 32'h0000_0004);
      idle(20);
      // Decoder pin path only after the output pin is reprogrammed away
      wr(`SSS_OFF_OUT_SEL, 32'h0000_0002);
      wr(`SSS_OFF_RX_CTRL, 32'h0000_0002);
      idle(20);
      rate_106a <= 1'b0;
      idle(10);
      frame_on <= 1'b0;
      idle(4);
   endtask

   // =================================================================
   // Verdict and hang guard
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cycle ceiling
   always @(posedge hclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         mismatches++;
         conclude();
      end
   end

   // Main sequence
   initial begin
      hresetn    = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0000_0000;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hsize      = 3'h2;
      hwdata     = 32'h0000_0000;
      core_in    = sss_core_t'(6'h00);
      rate_106a  = 1'b1;
      frame_on   = 1'b0;
      mon_on     = 1'b0;
      s_sel      = 8'h60;
      mismatches = 0;
      n_tests    = 0;
      cyc        = 0;
      do_reset();
      t_reset_values();
      t_decoder_codes();
      t_modulator_codes();
      t_output_codes();
      t_test_route();
      t_split();
      conclude();
   end
endmodule // sss_switch_bench
